// File: verilog/udsie_pkg.sv
`default_nettype none
package udsie_pkg;
  localparam int DESC_COUNT = 64;
  localparam int DESC_IDX_W = 6;
  // Status byte field positions
  localparam int BIT_OWNER = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_KEEP = 5;
  localparam int BIT_INC_OFF = 4;
  localparam int BIT_TOG_CHK = 3;
  localparam int BIT_STALL = 2;
  localparam int BIT_BC_HI = 0;
  // Flag / enable bit positions
  localparam int EV_BUS_RESET = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_ACTIVITY = 2;
  localparam int EV_XFER_DONE = 3;
  localparam int EV_IDLE = 4;
  localparam int EV_STALL = 5;
  localparam int EV_FRAME = 6;
  localparam int EV_COUNT = 7;
  // Register byte addresses
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h000;
  localparam logic [11:0] ADDR_IRQ_FLAGS = 12'h004;
  localparam logic [11:0] ADDR_DESC_BASE = 12'h100;
  localparam logic [6:0] IRQ_ENABLE_RESET = 7'h00;
  localparam logic [6:0] IRQ_FLAGS_RESET = 7'h00;

  typedef enum logic [1:0] {
    UDSIE_PID_OUT,
    UDSIE_PID_IN,
    UDSIE_PID_SETUP
  } udsie_pid_t;

  // Engine handshake answer to a token
  typedef enum logic [1:0] {
    UDSIE_ANS_NAK,
    UDSIE_ANS_ACK,
    UDSIE_ANS_STALL,
    UDSIE_ANS_DROP
  } udsie_ans_t;

  typedef struct packed {
    logic valid;
    logic [5:0] desc;
    udsie_pid_t pid;
    logic toggle;
  } udsie_token_t;

  typedef struct packed {
    logic valid;
    udsie_ans_t answer;
    logic [5:0] desc;
    logic [9:0] byteCount;
  } udsie_result_t;
endpackage : udsie_pkg
`default_nettype wire

// File: verilog/udsie_top.sv
// What this block does
// - 64 descriptor status bytes, processor read/write.
// - Toggle value ignored unless checking enabled.
// - Mismatch dropped when checking; SETUP never dropped.
// - Keep or stall bit holds ownership; else return.
// - Enable bit lets its flag interrupt.
// - Flags set regardless of enable bits.
// - Enable bit 7 reads zero; resets zero.
// - Bit 6 gates start-of-frame interrupt.
// - Bit 5 gates stall handshake interrupt.
// - Bit 4 gates idle detect interrupt.
// - Bit 3 gates transaction complete interrupt.
// - Bit 2 gates bus activity interrupt.
// - Bit 1 gates error interrupt.
// - Bit 0 gates bus reset interrupt.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module udsie_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // USB engine side
  input wire udsie_pkg::udsie_token_t token,
  input wire logic [7:0] byteCountLow,
  input wire logic [6:0] busEvents,
  output udsie_pkg::udsie_result_t result,
  // Interrupt
  output logic irq
);
  import udsie_pkg::*;

  logic [7:0] descMem [DESC_COUNT];
  logic [6:0] irqEnable_q, irqEnable_d;
  logic [6:0] irqFlags_q, irqFlags_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  udsie_result_t result_q, result_d;
  logic irq_q, irq_d;
  logic descWe;
  logic [5:0] descWaddr;
  logic [7:0] descWdata;

  function automatic logic isDescAddr(input logic [11:0] a);
    return a[11:8] == ADDR_DESC_BASE[11:8] && a[1:0] == 2'h0;
  endfunction : isDescAddr

  function automatic logic [5:0] descIndex(input logic [11:0] a);
    return a[7:2];
  endfunction : descIndex

  wire logic apbAccess = psel && penable && !pready_q;
  wire logic apbWrite = psel && penable && pready_q && pwrite && pstrb[0];
  wire logic [7:0] tokDesc = descMem[token.desc];
  wire logic engDescWe = token.valid && tokDesc[BIT_OWNER] && !tokDesc[BIT_STALL] && !tokDesc[BIT_KEEP];

  // Engine token handling
  always_comb begin
    logic togMismatch;
    togMismatch = 1'b0;
    result_d = '0;
    result_d.valid = token.valid;
    result_d.desc = token.desc;
    result_d.byteCount = {tokDesc[BIT_BC_HI +: 2], byteCountLow};
    togMismatch = tokDesc[BIT_TOG_CHK] && (token.toggle != tokDesc[BIT_TOGGLE]);
    if (!tokDesc[BIT_OWNER]) begin
      result_d.answer = UDSIE_ANS_NAK;
    end else if (tokDesc[BIT_STALL]) begin
      result_d.answer = UDSIE_ANS_STALL;
    end else if (togMismatch && token.pid != UDSIE_PID_SETUP) begin
      result_d.answer = UDSIE_ANS_DROP;
    end else begin
      result_d.answer = UDSIE_ANS_ACK;
    end
    if (!token.valid) begin
      result_d = '0;
    end
  end

  // Descriptor writes: the processor wins a same-cycle clash
  always_comb begin
    descWe = 1'b0;
    descWaddr = token.desc;
    descWdata = tokDesc;
    if (apbWrite && isDescAddr(paddr)) begin
      descWe = 1'b1;
      descWaddr = descIndex(paddr);
      descWdata = pwdata[7:0];
    end else if (engDescWe) begin
      descWe = 1'b1;
      descWdata = tokDesc & ~(8'h01 << BIT_OWNER);
    end
  end

  always_ff @(posedge core_clk) begin
    if (descWe) begin
      descMem[descWaddr] <= descWdata;
    end
  end

  // Registers, flags and bus answer
  always_comb begin
    logic [6:0] events;
    events = busEvents;
    if (result_q.valid && result_q.answer == UDSIE_ANS_STALL) begin
      events[EV_STALL] = 1'b1;
    end
    if (result_q.valid && result_q.answer == UDSIE_ANS_ACK) begin
      events[EV_XFER_DONE] = 1'b1;
    end
    irqEnable_d = irqEnable_q;
    irqFlags_d = irqFlags_q;
    prdata_d = 32'h0000_0000;
    pready_d = apbAccess;
    pslverr_d = 1'b0;
    if (apbAccess) begin
      if (paddr == ADDR_IRQ_ENABLE) begin
        prdata_d = {25'h0, irqEnable_q};
      end else if (paddr == ADDR_IRQ_FLAGS) begin
        prdata_d = {25'h0, irqFlags_q};
      end else if (isDescAddr(paddr)) begin
        prdata_d = {24'h0, descMem[descIndex(paddr)]};
      end else begin
        pslverr_d = 1'b1;
      end
    end
    // Writes land on the edge that completes the transfer, while pready is high
    if (apbWrite && paddr == ADDR_IRQ_ENABLE) begin
      irqEnable_d = pwdata[6:0];
    end
    if (apbWrite && paddr == ADDR_IRQ_FLAGS) begin
      irqFlags_d = irqFlags_q & ~pwdata[6:0];
    end
    irqFlags_d = irqFlags_d | events;
    irq_d = |(irqFlags_d & irqEnable_d);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqEnable_q <= IRQ_ENABLE_RESET;
      irqFlags_q <= IRQ_FLAGS_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      result_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irqEnable_q <= irqEnable_d;
      irqFlags_q <= irqFlags_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      result_q <= result_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign result = result_q;
  assign irq = irq_q;

  // Bus handshake and engine steps
  sequence stallTok;
    token.valid && tokDesc[BIT_OWNER] && tokDesc[BIT_STALL];
  endsequence

  sequence apbSetup;
    psel && !penable;
  endsequence

  sequence apbWaitState;
    psel && penable && !pready;
  endsequence

  sequence ownedTok;
    token.valid && tokDesc[BIT_OWNER] && !tokDesc[BIT_STALL];
  endsequence

  chk_stall_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    stallTok |=> result.answer == UDSIE_ANS_STALL && result.valid)
    else $error("stall bit did not give STALL");

  chk_stall_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
    (stallTok and !apbWrite) |=> descMem[$past(token.desc)] == $past(tokDesc))
    else $error("stalled descriptor changed");

  chk_not_owned: assert property (@(posedge core_clk) disable iff (!rst_n)
    token.valid && !tokDesc[BIT_OWNER] |=> result.answer == UDSIE_ANS_NAK)
    else $error("engine used core-owned descriptor");

  chk_setup_accept: assert property (@(posedge core_clk) disable iff (!rst_n)
    token.valid && token.pid == UDSIE_PID_SETUP && tokDesc[BIT_OWNER] && !tokDesc[BIT_STALL]
    |=> result.answer == UDSIE_ANS_ACK)
    else $error("setup data refused");

  chk_toggle_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    token.valid && tokDesc[BIT_OWNER] && !tokDesc[BIT_STALL] && !tokDesc[BIT_TOG_CHK]
    |=> result.answer == UDSIE_ANS_ACK)
    else $error("toggle checked while disabled");

  chk_drop_mismatch: assert property (@(posedge core_clk) disable iff (!rst_n)
    ownedTok ##0 (tokDesc[BIT_TOG_CHK] && token.pid != UDSIE_PID_SETUP && token.toggle != tokDesc[BIT_TOGGLE])
    |=> result.answer == UDSIE_ANS_DROP)
    else $error("toggle mismatch not dropped");

  chk_keep_owner: assert property (@(posedge core_clk) disable iff (!rst_n)
    token.valid && tokDesc[BIT_OWNER] && tokDesc[BIT_KEEP] && !apbWrite
    |=> descMem[$past(token.desc)][BIT_OWNER])
    else $error("kept descriptor returned");

  chk_release_owner: assert property (@(posedge core_clk) disable iff (!rst_n)
    engDescWe && !apbWrite |=> !descMem[$past(token.desc)][BIT_OWNER])
    else $error("descriptor not returned");

  chk_result_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !token.valid |=> !result.valid)
    else $error("result without token");

  chk_bytecount: assert property (@(posedge core_clk) disable iff (!rst_n)
    token.valid |=> result.byteCount[9:8] == $past(tokDesc[1:0]))
    else $error("byte count high bits wrong");

  chk_desc_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    apbWrite && isDescAddr(paddr) |=> descMem[$past(descIndex(paddr))] == $past(pwdata[7:0]))
    else $error("descriptor write lost");

  // Register bus
  chk_apb_one_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    apbSetup ##1 apbWaitState |=> pready)
    else $error("access not answered after one wait state");

  chk_pready_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  chk_err_no_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer carried data");

  chk_bit7_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    pready && !pslverr && $past(paddr) == ADDR_IRQ_ENABLE |-> prdata[7] == 1'b0)
    else $error("enable bit 7 not zero");

  chk_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    apbWrite && paddr == ADDR_IRQ_ENABLE |=> irqEnable_q == $past(pwdata[6:0]))
    else $error("enable write lost");

  chk_reset_values: assert property (@(posedge core_clk)
    !rst_n ##1 1'b1 |-> !irq && !pready && !pslverr && !result.valid && irqEnable_q == 7'h00
    && irqFlags_q == 7'h00)
    else $error("state not cleared by reset");

  // Flags and interrupt
  chk_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq == |(irqFlags_q & irqEnable_q))
    else $error("interrupt not gated by enables");

  chk_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(apbWrite && paddr == ADDR_IRQ_FLAGS) |=> (irqFlags_q & $past(irqFlags_q)) == $past(irqFlags_q))
    else $error("flag dropped without clear");

  chk_flag_poll: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_FRAME] |=> irqFlags_q[EV_FRAME])
    else $error("flag lost while disabled");

  chk_poll_stall: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_STALL] |=> irqFlags_q[EV_STALL])
    else $error("stall flag not set");

  chk_poll_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_IDLE] |=> irqFlags_q[EV_IDLE])
    else $error("idle flag not set");

  chk_poll_done: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_XFER_DONE] |=> irqFlags_q[EV_XFER_DONE])
    else $error("transfer flag not set");

  chk_poll_activity: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_ACTIVITY] |=> irqFlags_q[EV_ACTIVITY])
    else $error("activity flag not set");

  chk_poll_error: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_ERROR] |=> irqFlags_q[EV_ERROR])
    else $error("error flag not set");

  chk_poll_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_BUS_RESET] |=> irqFlags_q[EV_BUS_RESET])
    else $error("bus reset flag not set");

  chk_stall_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    result.valid && result.answer == UDSIE_ANS_STALL |=> irqFlags_q[EV_STALL])
    else $error("stall answer did not set flag");

  chk_done_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    result.valid && result.answer == UDSIE_ANS_ACK |=> irqFlags_q[EV_XFER_DONE])
    else $error("completed transfer did not set flag");

  chk_frame_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_FRAME] && irqEnable_q[EV_FRAME] && !(apbWrite && paddr == ADDR_IRQ_ENABLE)
    |=> irq)
    else $error("frame interrupt not raised");

  chk_stall_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_STALL] && irqEnable_q[EV_STALL] && !(apbWrite && paddr == ADDR_IRQ_ENABLE)
    |=> irq)
    else $error("stall interrupt not raised");

  chk_idle_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_IDLE] && irqEnable_q[EV_IDLE] && !(apbWrite && paddr == ADDR_IRQ_ENABLE)
    |=> irq)
    else $error("idle interrupt not raised");

  chk_done_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_XFER_DONE] && irqEnable_q[EV_XFER_DONE] && !(apbWrite && paddr == ADDR_IRQ_ENABLE)
    |=> irq)
    else $error("transfer interrupt not raised");

  chk_activity_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_ACTIVITY] && irqEnable_q[EV_ACTIVITY] && !(apbWrite && paddr == ADDR_IRQ_ENABLE)
    |=> irq)
    else $error("activity interrupt not raised");

  chk_error_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_ERROR] && irqEnable_q[EV_ERROR] && !(apbWrite && paddr == ADDR_IRQ_ENABLE)
    |=> irq)
    else $error("error interrupt not raised");

  chk_reset_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    busEvents[EV_BUS_RESET] && irqEnable_q[EV_BUS_RESET] && !(apbWrite && paddr == ADDR_IRQ_ENABLE)
    |=> irq)
    else $error("bus reset interrupt not raised");

  chk_frame_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    irqFlags_q == (7'h01 << EV_FRAME) && !irqEnable_q[EV_FRAME] |-> !irq)
    else $error("masked frame flag interrupted");

  chk_stall_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    irqFlags_q == (7'h01 << EV_STALL) && !irqEnable_q[EV_STALL] |-> !irq)
    else $error("masked stall flag interrupted");

  chk_idle_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    irqFlags_q == (7'h01 << EV_IDLE) && !irqEnable_q[EV_IDLE] |-> !irq)
    else $error("masked idle flag interrupted");

  chk_done_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    irqFlags_q == (7'h01 << EV_XFER_DONE) && !irqEnable_q[EV_XFER_DONE] |-> !irq)
    else $error("masked transfer flag interrupted");

  chk_activity_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    irqFlags_q == (7'h01 << EV_ACTIVITY) && !irqEnable_q[EV_ACTIVITY] |-> !irq)
    else $error("masked activity flag interrupted");

  chk_error_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    irqFlags_q == (7'h01 << EV_ERROR) && !irqEnable_q[EV_ERROR] |-> !irq)
    else $error("masked error flag interrupted");

  chk_reset_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    irqFlags_q == (7'h01 << EV_BUS_RESET) && !irqEnable_q[EV_BUS_RESET] |-> !irq)
    else $error("masked bus reset flag interrupted");
endmodule : udsie_top
`default_nettype wire

// File: sim/udsie_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module udsie_host_model (
  // Clock
  input wire logic core_clk,
  // Tokens and bus events toward the engine
  output udsie_pkg::udsie_token_t token,
  output logic [7:0] byteCountLow,
  output logic [6:0] busEvents
);
  import udsie_pkg::*;
  initial begin
    token = '0;
    byteCountLow = 8'h00;
    busEvents = 7'h00;
  end
  // Idle desc, toggle and byte count are inverted (pid is kept) so a stale value is never trusted
  task send_token(input logic [5:0] d, input udsie_pid_t p, input logic t, input logic [7:0] bc);
    @(posedge core_clk);
    token <= '{valid: 1'b1, desc: d, pid: p, toggle: t};
    byteCountLow <= bc;
    @(posedge core_clk);
    token <= '{valid: 1'b0, desc: ~d, pid: p, toggle: ~t};
    byteCountLow <= ~bc;
  endtask : send_token
  task pulse_events(input logic [6:0] ev);
    @(posedge core_clk);
    busEvents <= ev;
    @(posedge core_clk);
    busEvents <= 7'h00;
  endtask : pulse_events
endmodule : udsie_host_model
`default_nettype wire

// File: sim/udsie_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import udsie_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  udsie_token_t token;
  logic [7:0] byteCountLow;
  logic [6:0] busEvents;
  udsie_result_t result;
  int mismatches = 0;
  int num_checks = 0;
  logic [31:0] descMem [64];
  logic [31:0] enM = 0;
  logic [31:0] flagM = 0;
  logic [31:0] rd;
  logic err;
  udsie_top DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .token(token), .byteCountLow(byteCountLow), .busEvents(busEvents), .result(result), .irq(irq));
  udsie_host_model HOST (.core_clk(core_clk), .token(token), .byteCountLow(byteCountLow), .busEvents(busEvents));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Values read right after the edge are those the edge sampled
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task irq_check;
    repeat (2) @(posedge core_clk);
    #1 check(irq, |(enM & flagM));
  endtask : irq_check
  initial begin
    logic [31:0] v;
    logic [5:0] d;
    logic [1:0] p;
    logic [1:0] ans;
    logic t;
    logic [7:0] bc;
    int b;
    void'($urandom(92));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_IRQ_ENABLE, 0);
    check(rd, 0);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'hFF);
    apb(1'b0, ADDR_IRQ_ENABLE, 0);
    check(rd, 32'h7F);
    apb(1'b0, 12'h080, 0);
    check({rd[30:0], err}, 1);
    for (int i = 0; i < 64; i++) begin
      descMem[i] = $urandom % 256;
      apb(1'b1, ADDR_DESC_BASE + 12'(4 * i), descMem[i]);
    end
    for (int i = 0; i < 64; i += 9) begin
      apb(1'b0, ADDR_DESC_BASE + 12'(4 * i), 0);
      check(rd, descMem[i]);
    end
    for (int k = 0; k < 40; k++) begin
      enM = $urandom % 128;
      apb(1'b1, ADDR_IRQ_ENABLE, enM);
      d = $urandom;
      v = $urandom % 256;
      descMem[d] = v;
      apb(1'b1, ADDR_DESC_BASE + {4'h0, d, 2'b00}, v);
      p = $urandom % 3;
      t = $urandom;
      bc = $urandom;
      HOST.send_token(d, udsie_pid_t'(p), t, bc);
      #1;
      ans = !v[7] ? 2'h0 : v[2] ? 2'h2 : (v[3] && p != 2'h2 && t != v[6]) ? 2'h3 : 2'h1;
      check(result, {1'b1, ans, d, v[1:0], bc});
      if (ans == 2'h2) flagM |= 32'h20;
      if (ans == 2'h1) flagM |= 32'h08;
      if (v[7] && !v[2] && !v[5]) descMem[d] &= 32'h7F;
      irq_check;
      apb(1'b0, ADDR_DESC_BASE + {4'h0, d, 2'b00}, 0);
      check(rd, descMem[d]);
      apb(1'b0, ADDR_IRQ_FLAGS, 0);
      check(rd, flagM);
    end
    for (int k = 0; k < 14; k++) begin
      b = k % 7;
      enM = (k >= 7) ? (1 << b) : 0;
      apb(1'b1, ADDR_IRQ_ENABLE, enM);
      apb(1'b1, ADDR_IRQ_FLAGS, 32'h7F);
      HOST.pulse_events(7'(1 << b));
      flagM = 1 << b;
      irq_check;
      apb(1'b0, ADDR_IRQ_FLAGS, 0);
      check(rd, flagM);
    end
    complete_run;
  end
  initial begin
    #200000;
    mismatches++;
    complete_run;
  end
endmodule : tb
`default_nettype wire
